// ==== common/sls_pkg.sv ====
// constants, carriers and states of the sync-sequencing host controller
package sls_pkg;
    localparam int CLK_PERIOD_PS     = 20000;
    // dac clock period: plain default, set to the board's real figure
    localparam int DAC_CLK_PS        = 1000;
    localparam int SREF_MIN_DAC_CLKS = 4;
    localparam int SREF_HI_CYC       =
        (SREF_MIN_DAC_CLKS * DAC_CLK_PS) / CLK_PERIOD_PS + 1;
    localparam int SREF_LO_CYC       = 8;
    localparam int POLL_GAP_CYC      = 16;
    localparam int FRAME_W           = 24;
    localparam int LAST_BIT          = FRAME_W - 1;
    localparam int LAST_STEP         = 7;
    localparam int RBD_MAX           = 12;
    localparam int WIN_MIN           = 4;
    // device register addresses
    localparam logic [14:0] DEV_SKIP  = 15'h0036;
    localparam logic [14:0] DEV_WIN   = 15'h0039;
    localparam logic [14:0] DEV_ARM   = 15'h003A;
    localparam logic [14:0] DEV_EN    = 15'h003B;
    localparam logic [14:0] DEV_OFS   = 15'h0304;
    localparam logic [14:0] DEV_BUF   = 15'h0306;
    localparam logic [14:0] DEV_SUBCL = 15'h0458;
    // device register values and fields
    localparam logic [7:0] EN_PLAIN  = 8'hF1;
    localparam logic [7:0] EN_RAMP   = 8'hF3;
    localparam logic [7:0] ARM_CLEAR = 8'h00;
    localparam logic [7:0] ARM_SET   = 8'h02;
    localparam logic [7:0] WIN_MASK  = 8'h3F;
    localparam int         DONE_BIT  = 4;
    localparam int         SUBCL_LSB = 5;
    // own apb map
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_CFG  = 12'h004;
    localparam logic [11:0] A_LIM  = 12'h008;
    localparam logic [11:0] A_STAT = 12'h00C;
    localparam int CTRL_START  = 0;
    localparam int CTRL_RAMP   = 1;
    localparam int CTRL_SC_LSB = 2;
    localparam int STAT_BUSY   = 0;
    localparam int STAT_DONE   = 1;
    localparam int STAT_ERR    = 2;
    localparam int STAT_JIT    = 3;
    localparam int STAT_SYNC   = 4;
    localparam int STAT_RX_LSB = 8;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [7:0]  LIM_RST = 8'h08;

    typedef struct packed {
        logic        rd;
        logic [14:0] addr;
        logic [7:0]  data;
    } sls_frame_s;

    typedef struct packed {
        logic [7:0] bufdly;
        logic [7:0] offset;
        logic [7:0] window;
        logic [7:0] skip;
    } sls_cfg_s;

    typedef enum logic [2:0] {
        ST_IDLE, ST_WRITE, ST_SREF_HI, ST_SREF_LO, ST_WAIT, ST_READ, ST_DONE
    } sls_state_e;
endpackage

// ==== design/sls_ctrl_host.sv ====
// host controller: programs and arms the one-shot lmfc sync over spi
// Functional notes
// - hold each sysref pulse beyond four dac clocks
// - program window of at least four clocks
// - enable write is 0xF1, or 0xF3 with ramp
// - subclass 1: window and skip before arming
// - arm by writing 0x00 then 0x02
// - send enough sysref edges to pass skip count
// - lanes within one lmfc, both paths synced
// - frame offset below pclk cycles per multiframe
// - buffer delay not above cycles nor twelve
// - same computed offset and delay to every device
//
// The APB slave port was chosen for this implementation.
module sls_ctrl_host (
    input  wire logic         clk_in,
    input  wire logic         nrst_in,
    input  wire logic         psel_in,
    input  wire logic         penable_in,
    input  wire logic         pwrite_in,
    input  wire logic [11:0]  paddr_in,
    input  wire logic [31:0]  pwdata_in,
    output logic      [31:0]  prdata_out,
    output logic              pready_out,
    output logic              pslverr_out,
    output logic              spi_sclk_out,
    output logic              spi_cs_n_out,
    output logic              spi_mosi_out,
    input  wire logic         spi_miso_in,
    output logic              sysref_out,
    input  wire logic         align_jitter_irq_in,
    input  wire logic         link_sync_request_in
);
    import sls_pkg::*;

    sls_state_e        state;
    sls_cfg_s          cfg;
    logic [7:0]        pclk_per_mf;
    logic              ramp;
    logic [2:0]        subclass;
    logic              start_q;
    logic              done;
    logic              err;
    logic              jit;
    logic              sync_seen;
    logic [2:0]        step;
    logic [15:0]       tmr;
    logic [8:0]        edges;
    logic              launch;
    logic              spi_act;
    logic              spi_fin;
    logic [4:0]        bitc;
    logic [LAST_BIT:0] sh;
    logic [7:0]        rx;

    // first write of each step; reads always target the arm register
    function automatic sls_frame_s step_frame(input logic [2:0] s,
                                              input sls_cfg_s c,
                                              input logic [2:0] sc,
                                              input logic rmp);
        sls_frame_s f;
        f.rd = 1'b0;
        unique case (s)
            3'h0: begin
                f.addr = DEV_EN;
                f.data = rmp ? EN_RAMP : EN_PLAIN;
            end
            3'h1: begin
                f.addr = DEV_SUBCL;
                f.data = {sc, 5'h00};
            end
            3'h2: begin
                f.addr = DEV_WIN;
                f.data = c.window & WIN_MASK;
            end
            3'h3: begin
                f.addr = DEV_SKIP;
                f.data = c.skip;
            end
            3'h4: begin
                f.addr = DEV_OFS;
                f.data = c.offset;
            end
            3'h5: begin
                f.addr = DEV_BUF;
                f.data = c.bufdly;
            end
            3'h6: begin
                f.addr = DEV_ARM;
                f.data = ARM_CLEAR;
            end
            3'h7: begin
                f.addr = DEV_ARM;
                f.data = ARM_SET;
            end
        endcase
        return f;
    endfunction

    // apb decode
    wire logic setup_ph = psel_in & ~penable_in;
    wire logic wr_en    = psel_in & penable_in & pready_out & pwrite_in;
    wire logic mapped   = (paddr_in == A_CTRL) | (paddr_in == A_CFG) |
                          (paddr_in == A_LIM)  | (paddr_in == A_STAT);
    wire logic busy     = (state != ST_IDLE) & (state != ST_DONE);
    wire logic [31:0] stat_word = {16'h0000, rx, 3'h0, sync_seen, jit,
                                   err, done, busy};
    wire logic [31:0] rd_mux =
        (paddr_in == A_CTRL) ? {27'h0, subclass, ramp, 1'b0} :
        (paddr_in == A_CFG)  ? cfg :
        (paddr_in == A_LIM)  ? {24'h0, pclk_per_mf} :
        (paddr_in == A_STAT) ? stat_word : 32'h0000_0000;
    wire logic jit_clr = wr_en & (paddr_in == A_STAT) & pwdata_in[STAT_JIT];

    // settings are refused before any device write, so a bad set never
    // reaches the device half-written
    wire logic sc1      = (subclass == 3'h1);
    wire logic [7:0] buf_lim = (pclk_per_mf < 8'(RBD_MAX)) ?
                               pclk_per_mf : 8'(RBD_MAX);
    wire logic sc_ok    = (subclass <= 3'h1);
    wire logic ofs_ok   = cfg.offset < pclk_per_mf;
    wire logic buf_ok   = cfg.bufdly <= buf_lim;
    wire logic win_ok   = ~sc1 | ((cfg.window & WIN_MASK) >=
                                  8'(WIN_MIN));
    wire logic cfg_ok   = sc_ok & ofs_ok & buf_ok & win_ok;
    // subclass 0 leaves window and skip untouched and sends no sysref
    wire logic [2:0] next_step = (~sc1 & (step == 3'h1)) ? 3'h4 :
                                 step + 3'h1;
    wire sls_frame_s rd_frame  = '{rd: 1'b1, addr: DEV_ARM, data: 8'h00};
    wire sls_frame_s cur_frame = (state == ST_READ) ? rd_frame :
                                 step_frame(step, cfg, subclass, ramp);

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end else begin
            pready_out  <= setup_ph;
            pslverr_out <= setup_ph & ~mapped;
            prdata_out  <= setup_ph ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cfg         <= CFG_RST;
            pclk_per_mf <= LIM_RST;
            ramp        <= 1'b0;
            subclass    <= 3'h0;
            start_q     <= 1'b0;
        end else begin
            start_q <= wr_en & (paddr_in == A_CTRL) & pwdata_in[CTRL_START];
            if (wr_en & (paddr_in == A_CTRL)) begin
                ramp     <= pwdata_in[CTRL_RAMP];
                subclass <= pwdata_in[CTRL_SC_LSB +: 3];
            end
            if (wr_en & (paddr_in == A_CFG)) begin
                cfg <= pwdata_in;
            end
            if (wr_en & (paddr_in == A_LIM)) begin
                pclk_per_mf <= pwdata_in[7:0];
            end
        end
    end

    // device status inputs; a new irq beats a clear in the same cycle
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            jit       <= 1'b0;
            sync_seen <= 1'b0;
        end else begin
            jit       <= (jit & ~jit_clr) | align_jitter_irq_in;
            sync_seen <= link_sync_request_in;
        end
    end

    // sequencer
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state      <= ST_IDLE;
            step       <= 3'h0;
            tmr        <= 16'h0000;
            edges      <= 9'h000;
            launch     <= 1'b0;
            done       <= 1'b0;
            err        <= 1'b0;
            sysref_out <= 1'b0;
        end else begin
            launch <= 1'b0;
            unique case (state)
                ST_IDLE, ST_DONE: begin
                    if (start_q && cfg_ok) begin
                        state  <= ST_WRITE;
                        step   <= 3'h0;
                        launch <= 1'b1;
                        done   <= 1'b0;
                        err    <= 1'b0;
                    end else if (start_q) begin
                        err <= 1'b1;
                    end
                end
                ST_WRITE: begin
                    if (spi_fin && step == 3'(LAST_STEP)) begin
                        if (sc1) begin
                            state      <= ST_SREF_HI;
                            sysref_out <= 1'b1;
                            tmr        <= 16'(SREF_HI_CYC - 1);
                            edges      <= 9'h000;
                        end else begin
                            state  <= ST_READ;
                            launch <= 1'b1;
                        end
                    end else if (spi_fin) begin
                        step   <= next_step;
                        launch <= 1'b1;
                    end
                end
                ST_SREF_HI: begin
                    if (tmr == 16'h0000) begin
                        sysref_out <= 1'b0;
                        state      <= ST_SREF_LO;
                        tmr        <= 16'(SREF_LO_CYC - 1);
                    end else begin
                        tmr <= tmr - 16'h0001;
                    end
                end
                ST_SREF_LO: begin
                    if (tmr != 16'h0000) begin
                        tmr <= tmr - 16'h0001;
                    end else if (edges == {1'b0, cfg.skip}) begin
                        edges  <= edges + 9'h001;
                        state  <= ST_READ;
                        launch <= 1'b1;
                    end else begin
                        edges      <= edges + 9'h001;
                        state      <= ST_SREF_HI;
                        sysref_out <= 1'b1;
                        tmr        <= 16'(SREF_HI_CYC - 1);
                    end
                end
                ST_READ: begin
                    if (spi_fin && rx[DONE_BIT]) begin
                        state <= ST_DONE;
                        done  <= 1'b1;
                    end else if (spi_fin) begin
                        state <= ST_WAIT;
                        tmr   <= 16'(POLL_GAP_CYC - 1);
                    end
                end
                ST_WAIT: begin
                    if (tmr == 16'h0000) begin
                        state  <= ST_READ;
                        launch <= 1'b1;
                    end else begin
                        tmr <= tmr - 16'h0001;
                    end
                end
            endcase
        end
    end

    // spi master, sclk at half the system clock; mosi moves on the falling
    // edge and miso is taken on the rising one, msb first
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            spi_act      <= 1'b0;
            spi_fin      <= 1'b0;
            spi_cs_n_out <= 1'b1;
            spi_sclk_out <= 1'b0;
            spi_mosi_out <= 1'b0;
            bitc         <= 5'h00;
            sh           <= '0;
            rx           <= 8'h00;
        end else begin
            spi_fin <= 1'b0;
            if (launch) begin
                spi_act      <= 1'b1;
                spi_cs_n_out <= 1'b0;
                sh           <= cur_frame;
                spi_mosi_out <= cur_frame.rd;
                bitc         <= 5'h00;
            end else if (spi_act && !spi_sclk_out) begin
                spi_sclk_out <= 1'b1;
                rx           <= {rx[6:0], spi_miso_in};
            end else if (spi_act && bitc == 5'(LAST_BIT)) begin
                spi_sclk_out <= 1'b0;
                spi_act      <= 1'b0;
                spi_cs_n_out <= 1'b1;
                spi_fin      <= 1'b1;
                spi_mosi_out <= 1'b0;
            end else if (spi_act) begin
                spi_sclk_out <= 1'b0;
                bitc         <= bitc + 5'h01;
                sh           <= {sh[LAST_BIT-1:0], 1'b0};
                spi_mosi_out <= sh[LAST_BIT-1];
            end
        end
    end

    // checking helpers
    logic [7:0]  hi_len;
    logic        wrote_win;
    logic        wrote_skip;
    sls_frame_s  prev_frame;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hi_len     <= 8'h00;
            wrote_win  <= 1'b0;
            wrote_skip <= 1'b0;
            prev_frame <= '0;
        end else begin
            hi_len <= sysref_out ? hi_len + 8'h01 : 8'h00;
            if (start_q) begin
                wrote_win  <= 1'b0;
                wrote_skip <= 1'b0;
            end else if (launch) begin
                wrote_win  <= wrote_win | (cur_frame.addr == DEV_WIN);
                wrote_skip <= wrote_skip | (cur_frame.addr == DEV_SKIP);
            end
            if (launch) begin
                prev_frame <= cur_frame;
            end
        end
    end

    wire logic wr_launch = launch & ~cur_frame.rd;

    sequence s_frame_open;
        $fell(spi_cs_n_out) ##1 !spi_cs_n_out [*8];
    endsequence
    sequence s_arm_write;
        wr_launch && cur_frame.addr == DEV_ARM && cur_frame.data == ARM_SET;
    endsequence

    a_enable_value: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_launch && cur_frame.addr == DEV_EN |->
        cur_frame.data == (ramp ? EN_RAMP : EN_PLAIN))
        else $error("enable write carries wrong value");
    a_arm_order: assert property (@(posedge clk_in) disable iff (!nrst_in)
        s_arm_write |-> prev_frame.addr == DEV_ARM &&
        prev_frame.data == ARM_CLEAR)
        else $error("arm not preceded by clear");
    a_cfg_before_arm: assert property (@(posedge clk_in) disable iff (!nrst_in)
        s_arm_write and sc1 |-> wrote_win && wrote_skip)
        else $error("subclass 1 armed before window and skip");
    a_sref_width: assert property (@(posedge clk_in) disable iff (!nrst_in)
        $fell(sysref_out) |-> hi_len == 8'(SREF_HI_CYC))
        else $error("sysref pulse width wrong");
    a_edge_total: assert property (@(posedge clk_in) disable iff (!nrst_in)
        sc1 && $past(state) == ST_SREF_LO && state == ST_READ |->
        edges == {1'b0, cfg.skip} + 9'h001)
        else $error("wrong count of sysref edges");
    a_sc0_quiet: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !sc1 && state == ST_WRITE |=> !sysref_out [*4])
        else $error("sysref driven in subclass 0");
    a_offset_bound: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_launch && cur_frame.addr == DEV_OFS |->
        cur_frame.data < pclk_per_mf)
        else $error("frame offset not below cycles per multiframe");
    a_bufdly_bound: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_launch && cur_frame.addr == DEV_BUF |->
        cur_frame.data <= 8'(RBD_MAX) && cur_frame.data <= pclk_per_mf)
        else $error("buffer delay out of range");
    a_window_min: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_launch && cur_frame.addr == DEV_WIN |->
        cur_frame.data >= 8'(WIN_MIN) && cur_frame.data <= WIN_MASK)
        else $error("tolerance window below four clocks");
    a_subclass_field: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_launch && cur_frame.addr == DEV_SUBCL |->
        cur_frame.data[7:SUBCL_LSB] <= 3'h1)
        else $error("unsupported subclass written");
    a_done_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
        done && !start_q |=> done)
        else $error("done dropped without new arming");
    a_frame_len: assert property (@(posedge clk_in) disable iff (!nrst_in)
        s_frame_open |-> ##[39:40] spi_cs_n_out)
        else $error("spi frame length wrong");
endmodule

// ==== verif/sls_dev_model.sv ====
// device model: spi register file, one-shot lmfc alignment, sync lines
module sls_dev_model (
    input  wire logic clk_in,
    input  wire logic nrst_in,
    input  wire logic sclk_in,
    input  wire logic cs_n_in,
    input  wire logic mosi_in,
    output logic      miso_out,
    input  wire logic sysref_in,
    input  wire logic jit_force_in,
    output logic      irq_out,
    output logic      sync_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import sls_pkg::*;
    logic [7:0]  mem [logic [14:0]];
    logic [23:0] sh;
    logic [7:0]  rv;
    logic [7:0]  scr;
    int          cnt;
    int          ecnt;
    int          pulses;
    int          frames;
    logic        armed;
    logic        done;
    logic        arm_ok;
    logic        last_clr;
    logic        sref_q;

    function automatic logic [7:0] rdreg(input logic [14:0] a);
        logic [7:0] v;
        v = mem.exists(a) ? mem[a] : 8'h00;
        if (a == DEV_ARM)
            v[DONE_BIT] = done;
        return v;
    endfunction

    task automatic wreg(input logic [14:0] a, input logic [7:0] d);
        mem[a] = d;
        if (a == DEV_ARM) begin
            arm_ok = (d == ARM_SET) && last_clr;
            last_clr = (d == ARM_CLEAR);
            armed = d[1];
            ecnt = 0;
            if (d[1]) begin
                done = 1'b0;
                sync_out <= 1'b0;
            end
        end
    endtask

    // sysref is sampled on clk_in, standing in for the divided dac clock
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mem.delete();
            {cnt, ecnt, pulses, frames} = '0;
            {armed, done, arm_ok, last_clr} = '0;
            sref_q <= 1'b0;
            miso_out <= 1'b0;
            sync_out <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            scr = rdreg(DEV_SUBCL);
            // a released miso line toggles so stale bits never look valid
            if (cs_n_in) begin
                cnt = 0;
                miso_out <= ~miso_out;
            end else if (sclk_in) begin
                sh = {sh[22:0], mosi_in};
                cnt++;
                if (cnt == 16)
                    rv = rdreg(sh[14:0]);
                if (cnt >= 16 && cnt < 24)
                    miso_out <= rv[23 - cnt];
                if (cnt == 24) begin
                    frames++;
                    if (!sh[23])
                        wreg(sh[22:8], sh[7:0]);
                end
            end else if (cnt < 16)
                miso_out <= ~miso_out;
            if (sysref_in && !sref_q) begin
                pulses++;
                if (armed && !done && scr[7:5] == 3'h1) begin
                    if (ecnt == rdreg(DEV_SKIP)) begin
                        done = 1'b1;
                        sync_out <= 1'b1;
                    end else
                        ecnt++;
                end
            end
            if (armed && !done && scr[7:5] == 3'h0) begin
                done = 1'b1;
                sync_out <= 1'b1;
            end
            sref_q <= sysref_in;
            irq_out <= jit_force_in && done && scr[7:5] == 3'h1;
        end
    end
endmodule

// ==== verif/testbench.sv ====
// testbench: apb driver, read scoreboard and sync scenarios
`define CHK(nm, e, g) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("ERROR %s expected %0h seen %0h", nm, e, g); \
    end \
end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sls_pkg::*;
    logic        clk_in;
    logic        nrst_in;
    logic        psel_in;
    logic        penable_in;
    logic        pwrite_in;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic        sclk;
    logic        cs_n;
    logic        mosi;
    logic        miso;
    logic        sysref;
    logic        irq;
    logic        lsync;
    logic        jit_force;
    int          err_total;
    int          num_checks;
    logic [33:0] exp_q[$];
    logic [31:0] rd_val;
    logic [31:0] st;
    logic [7:0]  sk, wn, ofs, bd;
    logic        rmp;
    int          p0, f0;
    logic [2:0]  bsc [4] = '{3'h2, 3'h1, 3'h1, 3'h0};
    logic [31:0] bcfg [4] = '{32'h400, 32'h300, 32'h80400, 32'hD000000};
    logic [7:0]  blim [4] = '{8'h08, 8'h08, 8'h08, 8'h10};

    sls_ctrl_host u_dut (.clk_in(clk_in), .nrst_in(nrst_in),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .spi_sclk_out(sclk), .spi_cs_n_out(cs_n), .spi_mosi_out(mosi),
        .spi_miso_in(miso), .sysref_out(sysref),
        .align_jitter_irq_in(irq), .link_sync_request_in(lsync));
    sls_dev_model u_dev (.clk_in(clk_in), .nrst_in(nrst_in),
        .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi), .miso_out(miso),
        .sysref_in(sysref), .jit_force_in(jit_force), .irq_out(irq),
        .sync_out(lsync));

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    task automatic final_report();
        if (err_total == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ex = {compare, pslverr, prdata}; polls push a don't-care note
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [33:0] ex);
        int n;
        n = 0;
        if (!wr)
            exp_q.push_back(ex);
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 50);
        // a slave that never answers counts as a mismatch
        if (pready_out !== 1'b1)
            err_total++;
        rd_val = prdata_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic er);
        apb(1'b0, a, '0, {1'b1, er, e});
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, '0);
    endtask

    task automatic run(input logic [2:0] sc, input logic [31:0] cfg,
                       input logic [7:0] lim);
        int k;
        k = 0;
        wr(A_LIM, {24'h0, lim});
        wr(A_CFG, cfg);
        wr(A_CTRL, {27'h0, sc, rmp, 1'b1});
        do begin
            repeat (20) @(posedge clk_in);
            apb(1'b0, A_STAT, '0, '0);
            k++;
        end while (rd_val[STAT_BUSY] !== 1'b0 && k < 400);
        if (rd_val[STAT_BUSY] !== 1'b0)
            err_total++;
    endtask

    always @(posedge clk_in) begin
        logic [33:0] n;
        if (psel_in && penable_in && pready_out && !pwrite_in) begin
            n = exp_q.pop_front();
            if (n[33])
                `CHK("apb read", n[32:0], {pslverr_out, prdata_out})
        end
    end

    initial begin
        {psel_in, penable_in, pwrite_in, jit_force} <= '0;
        paddr_in <= '0;
        pwdata_in <= '0;
        nrst_in <= 1'b0;
        rd_val = $urandom(32'h3F07);
        repeat (6) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        rd(A_CTRL, 32'h0, 1'b0);
        rd(A_CFG, CFG_RST, 1'b0);
        rd(A_LIM, {24'h0, LIM_RST}, 1'b0);
        rd(A_STAT, 32'h0, 1'b0);
        rd(12'h010, 32'h0, 1'b1);
        sk = 8'($urandom_range(3, 0));
        wn = {2'($urandom), 6'($urandom_range(63, 4))};
        ofs = 8'($urandom_range(7, 0));
        bd = 8'($urandom_range(8, 0));
        rmp = 1'($urandom);
        st = {16'h0, ARM_SET | 8'h10, 8'h0};
        st[STAT_DONE] = 1'b1;
        st[STAT_SYNC] = 1'b1;
        p0 = u_dev.pulses;
        run(3'h1, {bd, ofs, wn, sk}, 8'h08);
        rd(A_STAT, st, 1'b0);
        `CHK("enable", rmp ? EN_RAMP : EN_PLAIN, u_dev.rdreg(DEV_EN))
        `CHK("subclass", 8'h20, u_dev.rdreg(DEV_SUBCL))
        `CHK("window", wn & WIN_MASK, u_dev.rdreg(DEV_WIN))
        `CHK("skip", sk, u_dev.rdreg(DEV_SKIP))
        `CHK("offset", ofs, u_dev.rdreg(DEV_OFS))
        `CHK("bufdly", bd, u_dev.rdreg(DEV_BUF))
        `CHK("arm order", 1'b1, u_dev.arm_ok)
        `CHK("pulses", sk + 1, u_dev.pulses - p0)
        jit_force <= 1'b1;
        repeat (4) @(posedge clk_in);
        rd(A_STAT, st | 32'h8, 1'b0);
        wr(A_STAT, 32'h8);
        rd(A_STAT, st | 32'h8, 1'b0);
        jit_force <= 1'b0;
        repeat (4) @(posedge clk_in);
        wr(A_STAT, 32'h8);
        rd(A_STAT, st, 1'b0);
        p0 = u_dev.pulses;
        run(3'h0, {8'h0C, 8'h0F, 16'h0}, 8'h10);
        rd(A_STAT, st, 1'b0);
        `CHK("no sysref", 0, u_dev.pulses - p0)
        `CHK("bufdly max", 8'h0C, u_dev.rdreg(DEV_BUF))
        `CHK("subclass", 8'h00, u_dev.rdreg(DEV_SUBCL))
        // refused starts keep done and the last byte, and flag err
        st[STAT_ERR] = 1'b1;
        for (int i = 0; i < 4; i++) begin
            f0 = u_dev.frames;
            run(bsc[i], bcfg[i], blim[i]);
            rd(A_STAT, st, 1'b0);
            `CHK("no frames", f0, u_dev.frames)
        end
        final_report();
    end

    initial begin
        repeat (40000) @(posedge clk_in);
        err_total++;
        final_report();
    end
endmodule
